// ==== pkg/ccms_map.svh ====
// offsets, field positions, reset values and timing counts of the scheduler
`ifndef CCMS_MAP_SVH
`define CCMS_MAP_SVH
// register offsets (byte addresses)
`define CCMS_REG_CTRL 12'h000
`define CCMS_REG_STATUS 12'h004
`define CCMS_REG_LANE_ID 12'h008
`define CCMS_REG_LEVER_ID 12'h00c
`define CCMS_REG_RNG_ID0 12'h010
`define CCMS_REG_RCFG_ID0 12'h020
`define CCMS_REG_CMD 12'h030
`define CCMS_MEM_BASE 12'h400
// control register fields
`define CCMS_CTRL_HB_MAP 0
`define CCMS_CTRL_HB_RNG 1
`define CCMS_CTRL_TGT_CFG 5
`define CCMS_CTRL_RELAY 9
`define CCMS_CMD_SEND_CFG 0
// power-on identifiers
`define CCMS_DEF_LANE_ID 11'h7a0
`define CCMS_DEF_LEVER_ID 11'h5a0
`define CCMS_DEF_RNG_ID0 11'h7b0
`define CCMS_DEF_RCFG_ID0 11'h5b0
`define CCMS_TGT_ID_STEP 11'h010
// message counts and payload slots
`define CCMS_LANE_MSGS 5'd16
`define CCMS_LEVER_MSGS 5'd3
`define CCMS_RNG_MSGS 5'd10
`define CCMS_RCFG_MSGS 5'd9
`define CCMS_HB_STEPS 5'd5
`define CCMS_STATUS_IDX 5'd5
`define CCMS_SLOT_LEVER 7'd16
`define CCMS_SLOT_RNG 7'd19
`define CCMS_SLOT_RCFG 7'd59
`define CCMS_SLOTS 95
// field codes
`define CCMS_NEG_FULL 16'h8000
`define CCMS_NO_LINE 8'hff
`define CCMS_NO_MAP 8'hff
`define CCMS_BYTE_BITS 8
`define CCMS_DLC 4'd8
// heartbeat timing
`define CCMS_HB_PERIOD_NS 1000000000
`define CCMS_CLK_PERIOD_NS 4
`define CCMS_HB_CYCLES (`CCMS_HB_PERIOD_NS / `CCMS_CLK_PERIOD_NS)
`endif

// ==== pkg/ccms_pkg.sv ====
// types of the measurement message scheduler
package ccms_pkg;
    typedef logic [10:0] ccms_id_t;
    typedef enum {CCMS_S_IDLE, CCMS_S_HB, CCMS_S_LANE, CCMS_S_LEVER,
        CCMS_S_RNG, CCMS_S_RCFG} ccms_state_t;
    typedef enum logic [1:0] {CCMS_K_PASS, CCMS_K_MAPST,
        CCMS_K_LANE} ccms_kind_t;
    typedef struct packed {
        ccms_state_t state;
        logic [4:0] idx;
        logic [1:0] tgt;
        logic [27:0] hb_timer;
        logic hb_pend;
        logic lane_pend;
        logic [3:0] rng_pend;
        logic cfg_pend;
        logic [9:0] ctrl;
        ccms_id_t lane_id;
        ccms_id_t lever_id;
        ccms_id_t [3:0] rng_id;
        ccms_id_t [3:0] rcfg_id;
        logic tx_valid;
        ccms_id_t tx_id;
        logic [63:0] tx_data;
        logic [31:0] rdata;
    } ccms_regs_t;
endpackage : ccms_pkg

// ==== core/ccms_payload_shaper.sv ====
// payload shaping: map status packing and lane invalid fill
`timescale 1ns/100ps
`include "ccms_map.svh"
module ccms_payload_shaper (
    // selection
    input wire ccms_pkg::ccms_kind_t kind,
    input wire logic [3:0] lane_msg,
    input wire logic lane_valid,
    // sources
    input wire logic [63:0] raw,
    input wire logic [31:0] distance_along_reference_line,
    input wire logic [7:0] loaded_map_index,
    // shaped payload
    output logic [63:0] payload
);
    import ccms_pkg::*;

    // invalid lane code per message layout, byte 0 at bits 7:0
    function automatic logic [63:0] lane_fill(input logic [3:0] m,
                                              input logic [63:0] r);
        logic [63:0] f;
        f = {4{`CCMS_NEG_FULL}};
        case (m)
            4'd1, 4'd2: f = {r[63:56], `CCMS_NO_LINE, {3{`CCMS_NEG_FULL}}};
            4'd5, 4'd6: f = {r[63:48], `CCMS_NEG_FULL, `CCMS_NO_LINE,
                `CCMS_NO_LINE, `CCMS_NEG_FULL};
            default: f = {4{`CCMS_NEG_FULL}};
        endcase
        return f;
    endfunction : lane_fill

    // offsets in bits from payload bit 0, byte k at bits 8k+7:8k
    always_comb begin
        payload = raw;
        case (kind)
            // signed distance at 0, unsigned index at 32
            CCMS_K_MAPST: payload = {24'h000000, loaded_map_index,
                distance_along_reference_line};
            CCMS_K_LANE: payload = lane_valid ? raw : lane_fill(lane_msg, raw);
            // raw codes pass with no offset added
            default: payload = raw;
        endcase
    end
endmodule : ccms_payload_shaper

// ==== core/ccms_scheduler.sv ====
// lane and range measurement CAN message scheduler
//
// Overview of operation
// - identifiers reset to defaults; registers replace every group's base
// - lane update sends sixteen lane messages on consecutive identifiers
// - lever arms of points A, B, C go on three consecutive identifiers
// - each of four targets has its own base, stepping by 10h
// - ten range measurement messages per target, indices 0 to 9
// - nine range configuration messages per target, indices 0 to 8
// - frames from target vehicles may be relayed onto our output
// - heartbeat set goes out about once per second regardless of data
// - heartbeat: each target's range status plus lane map status
// - range status heartbeat only for configured targets
// - map status heartbeat suppressed when no map is loaded
// - heartbeats disabled in configuration are never sent
// - signal offsets and lengths are in bits from payload start
// - signals are unsigned or two's complement signed integers
// - no additive offset; raw zero means physical zero
// - map status: signed 32-bit distance at 0, map index at 32
// - signed lane fields read 8000h while lane not computed
`timescale 1ns/100ps
`include "ccms_map.svh"
module ccms_scheduler #(
    parameter int unsigned HB_CYCLES = `CCMS_HB_CYCLES
) (
    // clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // register port
    input wire logic [11:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // measurement producer
    input wire logic lane_update,
    input wire logic lane_valid,
    input wire logic [3:0] rng_update,
    input wire logic [31:0] distance_along_reference_line,
    input wire logic [7:0] loaded_map_index,
    // relayed target frames
    input wire logic relay_valid,
    input wire ccms_pkg::ccms_id_t relay_id,
    input wire logic [63:0] relay_data,
    output logic relay_ready,
    // frame output to the CAN controller
    output logic tx_valid,
    input wire logic tx_ready,
    output ccms_pkg::ccms_id_t tx_id,
    output logic tx_ide,
    output logic [3:0] tx_dlc,
    output logic [63:0] tx_data
);
    import ccms_pkg::*;

    ccms_regs_t r;
    ccms_regs_t n;
    logic [63:0] pay_mem [0:`CCMS_SLOTS-1];
    logic [6:0] sel_slot;
    ccms_kind_t sel_kind;
    ccms_id_t sel_id;
    logic sel_ok;
    logic [63:0] shaped;
    logic free;
    logic map_loaded;
    logic is_mem;
    logic [6:0] mem_slot;

    // payload slot of message idx in group starting at base, target t
    function automatic logic [6:0] slot_of(input logic [6:0] base,
                                           input logic [1:0] t,
                                           input logic [4:0] per,
                                           input logic [4:0] i);
        return 7'(base + 7'(t) * 7'(per) + 7'(i));
    endfunction : slot_of

    assign is_mem = (reg_addr & 12'hc00) == `CCMS_MEM_BASE;
    assign mem_slot = reg_addr[9:3];
    // no map index means no map loaded
    assign map_loaded = loaded_map_index != `CCMS_NO_MAP;
    assign free = !r.tx_valid || tx_ready;

    // payload store; no reset so it maps onto plain memory
    always_ff @(posedge mclk) begin
        if (reg_wr && is_mem && mem_slot < 7'(`CCMS_SLOTS)) begin
            if (reg_addr[2]) begin
                pay_mem[mem_slot][63:32] <= reg_wdata;
            end else begin
                pay_mem[mem_slot][31:0] <= reg_wdata;
            end
        end
    end

    // what the current step would send
    always_comb begin
        sel_slot = 7'd0;
        sel_kind = CCMS_K_PASS;
        sel_id = r.lane_id;
        sel_ok = 1'b1;
        case (r.state)
            CCMS_S_HB: begin
                if (r.idx == 5'd0) begin
                    sel_kind = CCMS_K_MAPST;
                    // map status needs a loaded map
                    sel_ok = map_loaded && r.ctrl[`CCMS_CTRL_HB_MAP];
                end else begin
                    sel_slot = slot_of(`CCMS_SLOT_RNG, 2'(r.idx - 5'd1),
                        `CCMS_RNG_MSGS, `CCMS_STATUS_IDX);
                    // range status on its configured identifier
                    sel_id = r.rng_id[2'(r.idx - 5'd1)] + 11'(`CCMS_STATUS_IDX);
                    sel_ok = r.ctrl[`CCMS_CTRL_TGT_CFG + 32'(r.idx) - 1]
                        && r.ctrl[`CCMS_CTRL_HB_RNG + 32'(r.idx) - 1];
                end
            end
            CCMS_S_LANE: begin
                sel_slot = 7'(r.idx);
                // first lane message is the map status
                sel_kind = (r.idx == 5'd0) ? CCMS_K_MAPST : CCMS_K_LANE;
                sel_id = r.lane_id + 11'(r.idx);
            end
            CCMS_S_LEVER: begin
                sel_slot = `CCMS_SLOT_LEVER + 7'(r.idx);
                sel_id = r.lever_id + 11'(r.idx);
            end
            CCMS_S_RNG: begin
                sel_slot = slot_of(`CCMS_SLOT_RNG, r.tgt, `CCMS_RNG_MSGS, r.idx);
                sel_id = r.rng_id[r.tgt] + 11'(r.idx);
            end
            CCMS_S_RCFG: begin
                sel_slot = slot_of(`CCMS_SLOT_RCFG, r.tgt, `CCMS_RCFG_MSGS,
                    r.idx);
                sel_id = r.rcfg_id[r.tgt] + 11'(r.idx);
                sel_ok = r.ctrl[`CCMS_CTRL_TGT_CFG + 32'(r.tgt)];
            end
            default: sel_ok = 1'b0;
        endcase
    end

    ccms_payload_shaper u_shaper (
        .kind(sel_kind),
        .lane_msg(r.idx[3:0]),
        .lane_valid(lane_valid),
        .raw(pay_mem[sel_slot]),
        .distance_along_reference_line(distance_along_reference_line),
        .loaded_map_index(loaded_map_index),
        .payload(shaped)
    );

    // next state of everything
    always_comb begin
        n = r;
        relay_ready = 1'b0;
        if (r.tx_valid && tx_ready) begin
            n.tx_valid = 1'b0;
        end
        if (r.hb_timer == 28'(HB_CYCLES - 1)) begin
            n.hb_timer = 28'h0000000;
        end else begin
            n.hb_timer = r.hb_timer + 28'h0000001;
        end
        case (r.state)
            CCMS_S_IDLE: begin
                n.idx = 5'd0;
                n.tgt = 2'd0;
                if (r.hb_pend) begin
                    n.hb_pend = 1'b0;
                    n.state = CCMS_S_HB;
                end else if (r.lane_pend) begin
                    n.lane_pend = 1'b0;
                    n.state = CCMS_S_LANE;
                end else if (|r.rng_pend) begin
                    // lowest target first
                    for (int t = 3; t >= 0; t--) begin
                        if (r.rng_pend[t]) begin
                            n.tgt = 2'(t);
                        end
                    end
                    n.rng_pend[n.tgt] = 1'b0;
                    n.state = CCMS_S_RNG;
                end else if (r.cfg_pend) begin
                    n.cfg_pend = 1'b0;
                    n.state = CCMS_S_LEVER;
                end else if (!r.ctrl[`CCMS_CTRL_RELAY]) begin
                    // relaying off: frames are drained and dropped
                    relay_ready = 1'b1;
                end else if (free) begin
                    // relay target frame when otherwise quiet
                    relay_ready = 1'b1;
                    if (relay_valid) begin
                        n.tx_valid = 1'b1;
                        n.tx_id = relay_id;
                        n.tx_data = relay_data;
                    end
                end
            end
            CCMS_S_HB, CCMS_S_LANE, CCMS_S_LEVER, CCMS_S_RNG: begin
                if (free) begin
                    if (sel_ok) begin
                        n.tx_valid = 1'b1;
                        n.tx_id = sel_id;
                        n.tx_data = shaped;
                    end
                    n.idx = r.idx + 5'd1;
                    if (r.state == CCMS_S_HB && r.idx == `CCMS_HB_STEPS - 5'd1
                        || r.state == CCMS_S_LANE
                        && r.idx == `CCMS_LANE_MSGS - 5'd1
                        || r.state == CCMS_S_RNG
                        && r.idx == `CCMS_RNG_MSGS - 5'd1) begin
                        n.state = CCMS_S_IDLE;
                    end else if (r.state == CCMS_S_LEVER
                        && r.idx == `CCMS_LEVER_MSGS - 5'd1) begin
                        n.idx = 5'd0;
                        n.state = CCMS_S_RCFG;
                    end
                end
            end
            CCMS_S_RCFG: begin
                if (free) begin
                    if (sel_ok) begin
                        n.tx_valid = 1'b1;
                        n.tx_id = sel_id;
                        n.tx_data = shaped;
                    end
                    n.idx = r.idx + 5'd1;
                    // unconfigured targets are skipped in one cycle
                    if (!sel_ok || r.idx == `CCMS_RCFG_MSGS - 5'd1) begin
                        n.idx = 5'd0;
                        n.tgt = r.tgt + 2'd1;
                        if (r.tgt == 2'd3) begin
                            n.state = CCMS_S_IDLE;
                        end
                    end
                end
            end
            default: n.state = CCMS_S_IDLE;
        endcase
        // register writes
        if (reg_wr && !is_mem) begin
            case (reg_addr)
                `CCMS_REG_CTRL: n.ctrl = reg_wdata[9:0];
                `CCMS_REG_LANE_ID: n.lane_id = reg_wdata[10:0];
                `CCMS_REG_LEVER_ID: n.lever_id = reg_wdata[10:0];
                `CCMS_REG_CMD: begin
                    if (reg_wdata[`CCMS_CMD_SEND_CFG]) begin
                        n.cfg_pend = 1'b1;
                    end
                end
                default: begin
                    for (int t = 0; t < 4; t++) begin
                        if (reg_addr == `CCMS_REG_RNG_ID0 + 12'(4 * t)) begin
                            n.rng_id[t] = reg_wdata[10:0];
                        end
                        if (reg_addr == `CCMS_REG_RCFG_ID0 + 12'(4 * t)) begin
                            n.rcfg_id[t] = reg_wdata[10:0];
                        end
                    end
                end
            endcase
        end
        // event sets placed last so a set beats a same-cycle clear
        if (r.hb_timer == 28'(HB_CYCLES - 1)) begin
            n.hb_pend = 1'b1;
        end
        if (lane_update) begin
            n.lane_pend = 1'b1;
        end
        n.rng_pend = n.rng_pend | rng_update;
        // read data valid only in the cycle after the strobe
        n.rdata = 32'h00000000;
        if (reg_rd) begin
            if (is_mem) begin
                if (mem_slot < 7'(`CCMS_SLOTS)) begin
                    n.rdata = reg_addr[2] ? pay_mem[mem_slot][63:32]
                        : pay_mem[mem_slot][31:0];
                end
            end else begin
                case (reg_addr)
                    `CCMS_REG_CTRL: n.rdata = {22'h000000, r.ctrl};
                    `CCMS_REG_STATUS: n.rdata = {23'h000000, r.rng_pend,
                        r.cfg_pend, r.lane_pend, r.hb_pend, map_loaded,
                        r.state != CCMS_S_IDLE};
                    `CCMS_REG_LANE_ID: n.rdata = {21'h000000, r.lane_id};
                    `CCMS_REG_LEVER_ID: n.rdata = {21'h000000, r.lever_id};
                    default: begin
                        for (int t = 0; t < 4; t++) begin
                            if (reg_addr == `CCMS_REG_RNG_ID0 + 12'(4 * t)) begin
                                n.rdata = {21'h000000, r.rng_id[t]};
                            end
                            if (reg_addr == `CCMS_REG_RCFG_ID0 + 12'(4 * t)) begin
                                n.rdata = {21'h000000, r.rcfg_id[t]};
                            end
                        end
                    end
                endcase
            end
        end
    end

    // state register with power-on identifiers
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            r <= '0;
            r.state <= CCMS_S_IDLE;
            r.lane_id <= `CCMS_DEF_LANE_ID;
            r.lever_id <= `CCMS_DEF_LEVER_ID;
            for (int t = 0; t < 4; t++) begin
                r.rng_id[t] <= `CCMS_DEF_RNG_ID0 + 11'(t) * `CCMS_TGT_ID_STEP;
                r.rcfg_id[t] <= `CCMS_DEF_RCFG_ID0 + 11'(t) * `CCMS_TGT_ID_STEP;
            end
        end else begin
            r <= n;
        end
    end

    // frame outputs
    assign tx_valid = r.tx_valid;
    assign tx_id = r.tx_id;
    assign tx_data = r.tx_data;
    assign tx_ide = 1'b0;
    assign tx_dlc = `CCMS_DLC;
    assign reg_rdata = r.rdata;
endmodule : ccms_scheduler

// ==== tb/ccms_scheduler_asserts.sv ====
// port assertions of the measurement message scheduler
`timescale 1ns/100ps
module ccms_scheduler_asserts (
    // clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // register port
    input wire logic [11:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    // producer and relay
    input wire logic lane_valid,
    input wire logic [31:0] distance_along_reference_line,
    input wire logic [7:0] loaded_map_index,
    input wire logic relay_valid,
    input wire ccms_pkg::ccms_id_t relay_id,
    input wire logic [63:0] relay_data,
    input wire logic relay_ready,
    // frame output
    input wire logic tx_valid,
    input wire logic tx_ready,
    input wire ccms_pkg::ccms_id_t tx_id,
    input wire logic tx_ide,
    input wire logic [3:0] tx_dlc,
    input wire logic [63:0] tx_data
);
    import ccms_pkg::*;
    ccms_id_t lane_r, lever_r, rly_id_r;
    logic [63:0] rly_dat_r;
    logic relay_en_r;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    // shadows of id and control writes
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            lane_r <= 11'h7a0;
            lever_r <= 11'h5a0;
            relay_en_r <= 1'b0;
        end else if (reg_wr) begin
            if (reg_addr == 12'h008) lane_r <= reg_wdata[10:0];
            if (reg_addr == 12'h00c) lever_r <= reg_wdata[10:0];
            if (reg_addr == 12'h000) relay_en_r <= reg_wdata[9];
        end
    end
    // last relayed frame handed over
    always_ff @(posedge mclk) begin
        if (relay_valid && relay_ready) begin
            rly_id_r <= relay_id;
            rly_dat_r <= relay_data;
        end
    end
    sequence s_lane1_taken;
        tx_valid && tx_ready && tx_id == lane_r + 11'h1;
    endsequence
    sequence s_lane2_shown;
        ##[1:4] tx_valid && tx_id == lane_r + 11'h2;
    endsequence
    property p_frame_fmt;
        tx_valid |-> tx_ide == 1'b0 && tx_dlc == 4'h8;
    endproperty
    property p_hold;
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_id) && $stable(tx_data);
    endproperty
    property p_rdata_idle;
        !reg_rd |=> reg_rdata == 32'h0;
    endproperty
    property p_rd_lane;
        reg_rd && reg_addr == 12'h008 |=> reg_rdata == {21'h0, lane_r};
    endproperty
    property p_lane_seq;
        s_lane1_taken |-> s_lane2_shown;
    endproperty
    property p_map_fields;
        tx_valid && tx_id == lane_r |-> tx_data ==
            {24'h0, loaded_map_index, distance_along_reference_line};
    endproperty
    property p_lane_blank;
        tx_valid && tx_id == lane_r + 11'h3 && !lane_valid
            |-> tx_data == {4{16'h8000}};
    endproperty
    property p_relay;
        relay_valid && relay_ready && relay_en_r |=>
            ##[0:4] tx_valid && tx_id == rly_id_r && tx_data == rly_dat_r;
    endproperty
    property p_cmd_lever;
        reg_wr && reg_addr == 12'h030 && reg_wdata[0] |->
            ##[1:40] tx_valid && tx_id == lever_r;
    endproperty
    a_frame_fmt: assert property (p_frame_fmt)
        else $error("frame not standard eight byte");
    a_hold: assert property (p_hold)
        else $error("frame changed before taken");
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data outside read slot");
    a_rd_lane: assert property (p_rd_lane)
        else $error("lane base id read back wrong");
    a_lane_seq: assert property (p_lane_seq)
        else $error("lane ids not consecutive");
    a_map_fields: assert property (p_map_fields)
        else $error("map status payload wrong");
    a_lane_blank: assert property (p_lane_blank)
        else $error("blank lane fields wrong");
    a_relay: assert property (p_relay)
        else $error("relayed frame missing");
    a_cmd_lever: assert property (p_cmd_lever)
        else $error("lever arm frame missing");
endmodule : ccms_scheduler_asserts
bind ccms_scheduler ccms_scheduler_asserts i_ccms_scheduler_asserts (.mclk,
    .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .lane_valid,
    .distance_along_reference_line, .loaded_map_index, .relay_valid,
    .relay_id, .relay_data, .relay_ready, .tx_valid, .tx_ready, .tx_id,
    .tx_ide, .tx_dlc, .tx_data);

// ==== tb/ccms_rx_model.sv ====
// receiving node on the far side of the frame output
`timescale 1ns/100ps
module ccms_rx_model (
    // clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // pacing
    input wire logic slow,
    // frame handshake
    input wire logic tx_valid,
    output logic tx_ready
);
    // slow: ready a cycle after each offer, like a loaded bus
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            tx_ready <= 1'b0;
        end else begin
            tx_ready <= slow ? tx_valid && !tx_ready : 1'b1;
        end
    end
endmodule : ccms_rx_model

// ==== tb/ccms_scheduler_tb.sv ====
// self-checking bench of the message scheduler
`timescale 1ns/100ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin mismatches++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module ccms_scheduler_tb;
    import ccms_pkg::*;
    localparam int HB = 50;
    logic mclk = 1'b0, nrst = 1'b0;
    logic [11:0] reg_addr = 12'h000;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0, reg_rd = 1'b0;
    logic [31:0] reg_rdata, d;
    logic lane_update = 1'b0, lane_valid = 1'b1;
    logic [3:0] rng_update = 4'h0;
    logic [31:0] distance_along_reference_line = 32'hfffe_1234;
    logic [7:0] loaded_map_index = 8'h03;
    logic relay_valid = 1'b0;
    ccms_id_t relay_id = 11'h123;
    logic [63:0] relay_data = 64'h0123_4567_89ab_cdef;
    logic relay_ready, tx_valid, tx_ready, tx_ide, slow = 1'b0;
    ccms_id_t tx_id;
    logic [3:0] tx_dlc;
    logic [63:0] tx_data;
    ccms_id_t fid[$];
    logic [63:0] fdat[$];
    int ftime[$];
    int cyc = 0, mismatches = 0, checks = 0;
    ccms_scheduler #(.HB_CYCLES(HB)) i_ccms_scheduler (.mclk, .nrst,
        .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .lane_update,
        .lane_valid, .rng_update, .distance_along_reference_line,
        .loaded_map_index, .relay_valid, .relay_id, .relay_data,
        .relay_ready, .tx_valid, .tx_ready, .tx_id, .tx_ide, .tx_dlc,
        .tx_data);
    ccms_rx_model i_ccms_rx_model (.mclk, .nrst, .slow, .tx_valid,
        .tx_ready);
    // clock
    always #2 mclk = ~mclk;
    // frames taken, stamped with the cycle
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
            fid.push_back(tx_id);
            fdat.push_back(tx_data);
            ftime.push_back(cyc);
        end
    end
    task automatic end_sim();
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : end_sim
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [11:0] a, output logic [31:0] v);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
    endtask : rd
    task automatic kick(input logic l, input logic [3:0] r);
        @(posedge mclk);
        lane_update <= l;
        rng_update <= r;
        @(posedge mclk);
        lane_update <= 1'b0;
        rng_update <= 4'h0;
    endtask : kick
    task automatic clr();
        @(negedge mclk);
        fid.delete();
        fdat.delete();
        ftime.delete();
    endtask : clr
    // wait for n frames plus stragglers
    task automatic grab(input int n);
        for (int k = 0; k < 400 && fid.size() < n; k++) @(posedge mclk);
        repeat (24) @(posedge mclk);
    endtask : grab
    task automatic t_regs();
        rd(12'h008, d);
        `CHK(d, 32'h7a0)
        rd(12'h00c, d);
        `CHK(d, 32'h5a0)
        for (int t = 0; t < 4; t++) begin
            rd(12'h010 + 12'(4 * t), d);
            `CHK(d, 32'h7b0 + 32'(16 * t))
            rd(12'h020 + 12'(4 * t), d);
            `CHK(d, 32'h5b0 + 32'(16 * t))
        end
        wr(12'h008, 32'h234);
        rd(12'h008, d);
        `CHK(d, 32'h234)
        wr(12'h008, 32'h7a0);
        wr(12'h3fc, 32'hffff_ffff);
        rd(12'h3fc, d);
        `CHK(d, 32'h0)
    endtask : t_regs
    task automatic t_lane_valid();
        clr();
        kick(1'b1, 4'h0);
        grab(16);
        `CHK(fid.size(), 16)
        for (int i = 0; i < 16; i++) `CHK(fid[i], 11'h7a0 + 11'(i))
        `CHK(fdat[0], {24'h0, 8'h03, 32'hfffe_1234})
        `CHK(fdat[0][39:32], 8'h03)
        `CHK($signed(fdat[0][31:0]), -126412)
    endtask : t_lane_valid
    task automatic t_lane_blank();
        @(posedge mclk);
        lane_valid <= 1'b0;
        slow <= 1'b1;
        distance_along_reference_line <= 32'h0;
        clr();
        kick(1'b1, 4'h0);
        grab(16);
        `CHK(fdat[0][31:0], 32'h0)
        `CHK(fdat[1][55:0], {8'hff, {3{16'h8000}}})
        `CHK(fdat[3], {4{16'h8000}})
        `CHK({fdat[5][47:32], fdat[5][15:0]}, {2{16'h8000}})
        `CHK(fdat[5][31:16], 16'hffff)
        @(posedge mclk);
        lane_valid <= 1'b1;
        slow <= 1'b0;
    endtask : t_lane_blank
    task automatic t_range();
        wr(12'h014, 32'h300);
        clr();
        kick(1'b0, 4'b0011);
        grab(20);
        `CHK(fid.size(), 20)
        for (int i = 0; i < 10; i++) begin
            `CHK(fid[i], 11'h7b0 + 11'(i))
            `CHK(fid[10 + i], 11'h300 + 11'(i))
        end
    endtask : t_range
    task automatic t_cmd();
        wr(12'h000, 32'h0a0);
        wr(12'h00c, 32'h120);
        clr();
        wr(12'h030, 32'h1);
        grab(21);
        `CHK(fid.size(), 21)
        for (int i = 0; i < 3; i++) `CHK(fid[i], 11'h120 + 11'(i))
        for (int i = 0; i < 9; i++) begin
            `CHK(fid[3 + i], 11'h5b0 + 11'(i))
            `CHK(fid[12 + i], 11'h5d0 + 11'(i))
        end
    endtask : t_cmd
    task automatic t_heartbeat();
        int g;
        // map on, range on for 0 and 2, targets 0 and 1 configured
        wr(12'h000, 32'h06b);
        clr();
        grab(1);
        clr();
        grab(2);
        `CHK(fid.size(), 2)
        `CHK(fid[0], 11'h7a0)
        `CHK(fid[1], 11'h7b5)
        g = ftime[1];
        loaded_map_index <= 8'hff;
        clr();
        grab(1);
        `CHK(fid.size(), 1)
        `CHK(fid[0], 11'h7b5)
        g = ftime[0] - g;
        `CHK(g >= HB - 2 && g <= HB + 4, 1'b1)
        wr(12'h000, 32'h060);
        loaded_map_index <= 8'h03;
        clr();
        repeat (2 * HB + 10) @(posedge mclk);
        `CHK(fid.size(), 0)
    endtask : t_heartbeat
    task automatic send_relay();
        @(posedge mclk);
        relay_valid <= 1'b1;
        @(posedge mclk);
        for (int k = 0; k < 50 && relay_ready !== 1'b1; k++) @(posedge mclk);
        `CHK(relay_ready, 1'b1)
        relay_valid <= 1'b0;
    endtask : send_relay
    task automatic t_relay();
        wr(12'h000, 32'h200);
        clr();
        send_relay();
        grab(1);
        `CHK(fid[0], 11'h123)
        `CHK(fdat[0], 64'h0123_4567_89ab_cdef)
        wr(12'h000, 32'h0);
        clr();
        send_relay();
        repeat (20) @(posedge mclk);
        `CHK(fid.size(), 0)
    endtask : t_relay
    // main sequence
    initial begin
        repeat (8) @(posedge mclk);
        nrst <= 1'b1;
        t_regs();
        t_lane_valid();
        t_lane_blank();
        t_range();
        t_cmd();
        t_heartbeat();
        t_relay();
        end_sim();
    end
    // watchdog, well past the run length
    initial begin
        repeat (20000) @(posedge mclk);
        mismatches++;
        end_sim();
    end
endmodule : ccms_scheduler_tb
